// file: src/fsp_spi_slave.sv
// SPI slave front end and byte array of a 32K x 8 serial memory
`timescale 1ns/1ps
`default_nettype none
module fsp_spi_slave import fsp_pkg::*; #(
   parameter int DEPTH = MEM_DEPTH
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   input wire logic HOLD_N,
   input wire logic WP_N,
   output logic SO,
   output logic SO_OE_N,
   output logic STANDBY,
   output logic [7:0] STATUS
);
   localparam fsp_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};

   fsp_pins_t pins_raw;
   fsp_pins_t pins_s;
   fsp_state_t state_q;
   logic [2:0] bit_cnt_q;
   logic [6:0] shin_q;
   logic addr_byte_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] status_q;
   logic [7:0] tx_q;
   logic so_q;
   logic sel_q;
   logic sck_prev_q;
   logic op_is_read_q;
   logic op_write_seen_q;
   logic [DATA_W-1:0] mem [DEPTH];

   logic hold_ok;
   logic active;
   logic sel_start;
   logic sel_end;
   logic sck_rise;
   logic sck_fall;
   logic byte_done;
   logic [7:0] rx_byte;
   logic wel;
   logic talking;
   logic [7:0] tx_load;

   // True when the address falls inside the block-protected range
   function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
      logic hit;
      hit = 1'b1;
      unique case (bp)
         BP_NONE: hit = 1'b0;
         BP_QUARTER: hit = (a >= QUARTER_BASE);
         BP_HALF: hit = (a >= HALF_BASE);
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction

   // Pointer step; wraps inside the 15-bit space
   function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
      return ADDR_W'(a + ADDR_W'(1));
   endfunction

   assign pins_raw = '{cs_n: CS_N, sck: SCK, si: SI, hold_n: HOLD_N, wp_n: WP_N};

   fsp_sync #(.W($bits(fsp_pins_t)), .INIT(PINS_IDLE)) u_sync (
      .clk(CLOCK),
      .rst(RST),
      .d(pins_raw),
      .q(pins_s)
   );

   assign hold_ok = pins_s.hold_n;
   assign wel = status_q[SR_WEL_BIT];

   // Select edges only count while not paused
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sel_q <= 1'b0;
      end else if (hold_ok) begin
         sel_q <= ~pins_s.cs_n;
      end
   end

   assign sel_start = hold_ok & ~pins_s.cs_n & ~sel_q;
   assign sel_end = hold_ok & pins_s.cs_n & sel_q;
   assign active = sel_q & ~pins_s.cs_n;
   // Follows the select register, so a pause freezes it too
   assign STANDBY = ~sel_q;

   // Edge history frozen during pause so a resume makes no false edge
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sck_prev_q <= 1'b0;
      end else if (hold_ok) begin
         sck_prev_q <= pins_s.sck;
      end
   end

   assign sck_rise = hold_ok & active & pins_s.sck & ~sck_prev_q;
   assign sck_fall = hold_ok & active & ~pins_s.sck & sck_prev_q;
   assign byte_done = sck_rise & (bit_cnt_q == 3'h7);
   assign rx_byte = {shin_q, pins_s.si};

   // Bit counter and input shifter; idle level of the clock is irrelevant
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         bit_cnt_q <= 3'h0;
         shin_q <= 7'h00;
      end else if (sel_start) begin
         bit_cnt_q <= 3'h0;
      end else if (sck_rise) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shin_q <= rx_byte[6:0];
      end
   end

   // Command sequencer
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_q <= ST_CMD;
         addr_byte_q <= 1'b0;
      end else if (sel_start) begin
         state_q <= ST_CMD;
         addr_byte_q <= 1'b0;
      end else if (byte_done) begin
         unique case (state_q)
            ST_CMD: begin
               unique case (rx_byte)
                  OP_READ, OP_WRITE: state_q <= ST_ADDR;
                  OP_RDSR: state_q <= ST_RDSR;
                  OP_WRSR: state_q <= ST_WRSR;
                  default: state_q <= ST_IGNORE;
               endcase
               addr_byte_q <= 1'b0;
            end
            ST_ADDR: begin
               addr_byte_q <= 1'b1;
               if (addr_byte_q) begin
                  state_q <= op_is_read_q ? ST_READ : ST_WRITE;
               end
            end
            ST_WRSR: state_q <= ST_IGNORE;
            default: state_q <= state_q;
         endcase
      end
   end

   // Remembers whether the open command reads or writes the array
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         op_is_read_q <= 1'b0;
      end else if (byte_done && state_q == ST_CMD) begin
         op_is_read_q <= (rx_byte == OP_READ);
      end
   end

   // Address pointer: loaded MSB first, advanced per byte, wraps in 15 bits
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         addr_q <= '0;
      end else if (byte_done && state_q == ST_ADDR) begin
         if (addr_byte_q) begin
            addr_q[7:0] <= rx_byte;
         end else begin
            addr_q[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
         end
      end else if (byte_done && state_q == ST_WRITE) begin
         addr_q <= addr_inc(addr_q);
      end else if (sck_fall && state_q == ST_READ && bit_cnt_q == 3'h0) begin
         addr_q <= addr_inc(addr_q);
      end
   end

   // Status register and write enable latch
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         status_q <= SR_RESET;
      end else if (byte_done && state_q == ST_CMD && rx_byte == OP_WREN) begin
         status_q[SR_WEL_BIT] <= 1'b1;
      end else if (byte_done && state_q == ST_CMD && rx_byte == OP_WRDI) begin
         status_q[SR_WEL_BIT] <= 1'b0;
      end else if (byte_done && state_q == ST_WRSR) begin
         if (wel && !(status_q[SR_PPE_BIT] && !pins_s.wp_n)) begin
            status_q <= (status_q & ~SR_WRITE_MASK) | (rx_byte & SR_WRITE_MASK);
         end
      end else if (sel_end && (state_q == ST_WRITE || op_write_seen_q)) begin
         status_q[SR_WEL_BIT] <= 1'b0;
      end
   end

   // Set once a status or array write command has been given in this select
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         op_write_seen_q <= 1'b0;
      end else if (sel_start) begin
         op_write_seen_q <= 1'b0;
      end else if (byte_done && state_q == ST_CMD) begin
         op_write_seen_q <= (rx_byte == OP_WRSR) || (rx_byte == OP_WRITE);
      end
   end

   // Byte lands in the array on its eighth bit, no busy time
   always_ff @(posedge CLOCK) begin
      if (byte_done && state_q == ST_WRITE && wel && !is_protected(status_q[SR_BP_HI:SR_BP_LO], addr_q)) begin
         mem[addr_q] <= rx_byte;
      end
   end

   assign tx_load = (state_q == ST_READ) ? mem[addr_q] : status_q;
   assign talking = (state_q == ST_READ) || (state_q == ST_RDSR);

   // Output shifter, moves on the falling edge
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         tx_q <= 8'h00;
         so_q <= 1'b0;
      end else if (sck_fall && talking) begin
         if (bit_cnt_q == 3'h0) begin
            so_q <= tx_load[7];
            tx_q <= {tx_load[6:0], 1'b0};
         end else begin
            so_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   assign SO = so_q;
   assign SO_OE_N = ~(active & hold_ok & talking);
   assign STATUS = status_q;
endmodule
`default_nettype wire

// file: src/fsp_pkg.sv
// Shared constants and types for the serial memory SPI slave
package fsp_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 32768;
   localparam int SYNC_STAGES = 2;
   // Serial clock limit, and the fastest edge spacing in system clocks
   localparam int SCK_MAX_MHZ = 20;
   localparam int CLK_MHZ = 100;
   localparam int SCK_MIN_CYC = CLK_MHZ / SCK_MAX_MHZ;
   // Command opcodes
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   // Status register field positions and reset value
   localparam int SR_PPE_BIT = 7;
   localparam int SR_BP_HI = 3;
   localparam int SR_BP_LO = 2;
   localparam int SR_WEL_BIT = 1;
   localparam logic [7:0] SR_WRITE_MASK = 8'h8C;
   localparam logic [7:0] SR_RESET = 8'h00;
   // Block protect codes and lower bounds of protected ranges
   localparam logic [1:0] BP_NONE = 2'h0;
   localparam logic [1:0] BP_QUARTER = 2'h1;
   localparam logic [1:0] BP_HALF = 2'h2;
   localparam logic [14:0] QUARTER_BASE = 15'h6000;
   localparam logic [14:0] HALF_BASE = 15'h4000;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
      logic wp_n;
   } fsp_pins_t;

   typedef enum logic [6:0] {
      ST_CMD = 7'h01,
      ST_ADDR = 7'h02,
      ST_READ = 7'h04,
      ST_WRITE = 7'h08,
      ST_RDSR = 7'h10,
      ST_WRSR = 7'h20,
      ST_IGNORE = 7'h40
   } fsp_state_t;
endpackage

// file: src/fsp_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module fsp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: sim/fsp_spi_slave_assertions.sv
// Port-level checks for the serial memory SPI slave
`timescale 1ns/1ps
`default_nettype none
module fsp_spi_slave_assertions (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SI,
   input wire logic HOLD_N,
   input wire logic WP_N,
   input wire logic SO,
   input wire logic SO_OE_N,
   input wire logic STANDBY,
   input wire logic [7:0] STATUS
);
   logic sck_q;
   logic [3:0] since_q;
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   // Cycles since the serial clock was last seen falling
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sck_q <= 1'b0;
         since_q <= 4'hF;
      end else begin
         sck_q <= SCK;
         since_q <= (sck_q && !SCK) ? 4'h0 : ((since_q == 4'hF) ? since_q : since_q + 4'h1);
      end
   end
   sequence s_desel; (CS_N && HOLD_N) [*4]; endsequence
   sequence s_sel; (!CS_N && HOLD_N) [*4]; endsequence
   sequence s_paused; (!HOLD_N) [*4]; endsequence
   sequence s_guard; (STATUS[7] && !WP_N) [*4]; endsequence
   property p_standby; s_desel |-> STANDBY && SO_OE_N; endproperty
   property p_select; s_sel |-> !STANDBY; endproperty
   property p_hold_oe; s_paused |-> SO_OE_N; endproperty
   property p_hold_frz; s_paused |=> $stable(STATUS) && $stable(SO) && $stable(STANDBY); endproperty
   property p_guard; s_guard |=> $stable(STATUS[7:2]); endproperty
   property p_so_edge; $changed(SO) && !SO_OE_N && $past(!SO_OE_N) |-> since_q inside {[1:4]}; endproperty
   property p_stat_sel; $changed(STATUS) |-> !$past(STANDBY); endproperty
   property p_wel_set; $rose(STATUS[1]) |-> !STANDBY; endproperty
   a_standby: assert property (p_standby) else $error("deselected but not in standby");
   a_select: assert property (p_select) else $error("selected but still in standby");
   a_hold_oe: assert property (p_hold_oe) else $error("output driven while paused");
   a_hold_frz: assert property (p_hold_frz) else $error("state moved while paused");
   a_guard: assert property (p_guard) else $error("guarded status written");
   a_so_edge: assert property (p_so_edge) else $error("output moved away from a clock fall");
   a_stat_sel: assert property (p_stat_sel) else $error("status changed in standby");
   a_wel_set: assert property (p_wel_set) else $error("write latch set while deselected");
endmodule
`default_nettype wire

// file: sim/fsp_spi_master.sv
// Behavioural SPI bus master for the serial memory pins
`timescale 1ns/1ps
`default_nettype none
module fsp_spi_master import fsp_pkg::*; (
   input wire logic clk,
   input wire logic so_line,
   output var fsp_pins_t pins
);
   logic mode3;
   int n_half;
   initial begin
      pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      mode3 = 1'b0;
      n_half = 0;
   end
   // Six and seven cycle halves mix to a 125 ns average period
   task automatic half();
      n_half++;
      repeat ((n_half % 4 == 0) ? 7 : 6) @(negedge clk);
   endtask
   task automatic start();
      pins.sck = mode3;
      half();
      pins.cs_n = 1'b0;
      half();
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         pins.sck = 1'b0;
         pins.si = tx[i];
         half();
         pins.sck = 1'b1;
         rx[i] = so_line;
         half();
      end
   endtask
   task automatic stop();
      pins.sck = mode3;
      half();
      pins.cs_n = 1'b1;
      // Released data line no longer shows the last bit
      pins.si = ~pins.si;
      half();
   endtask
   // Pause with clock and select noise, clock held low around it
   task automatic pause();
      pins.sck = 1'b0;
      half();
      pins.hold_n = 1'b0;
      repeat (4) begin
         pins.sck = ~pins.sck;
         pins.cs_n = ~pins.cs_n;
         half();
      end
      pins.hold_n = 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// file: sim/fsp_spi_slave_bench.sv
// Self-checking bench for the serial memory SPI slave
`timescale 1ns/1ps
`default_nettype none
module fsp_spi_slave_bench import fsp_pkg::*;;
   logic clk;
   logic rst;
   fsp_pins_t pins;
   logic so;
   logic so_oe_n;
   logic standby;
   logic [7:0] status;
   logic [7:0] rx;
   logic [7:0] exp_mem [int];
   logic e_ppe;
   logic e_wel;
   logic [1:0] e_bp;
   logic [14:0] a;
   logic [14:0] a_list [5] = '{15'h0000, 15'h4000, 15'h5FFF, 15'h6000, 15'h7FFF};
   int n_fail;
   int comparisons;
   // Pull-up on the shared output line
   wire logic so_line = so_oe_n ? 1'b1 : so;
   fsp_spi_slave i_dut (.CLOCK(clk), .RST(rst), .CS_N(pins.cs_n), .SCK(pins.sck), .SI(pins.si),
      .HOLD_N(pins.hold_n), .WP_N(pins.wp_n), .SO(so), .SO_OE_N(so_oe_n), .STANDBY(standby), .STATUS(status));
   fsp_spi_master mst (.clk(clk), .so_line(so_line), .pins(pins));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         n_fail++;
         $display("mismatch at %0t: %h vs %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d of %0d comparisons", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   function automatic bit blocked(input logic [14:0] x);
      return e_bp == 2'h3 || (e_bp == BP_QUARTER && x >= QUARTER_BASE) || (e_bp == BP_HALF && x >= HALF_BASE);
   endfunction
   task automatic op1(input logic [7:0] o);
      mst.start();
      mst.xfer(o, rx);
      mst.stop();
      if (o == OP_WREN || o == OP_WRDI) begin
         e_wel = (o == OP_WREN);
      end
   endtask
   task automatic rdsr();
      mst.start();
      mst.xfer(OP_RDSR, rx);
      mst.xfer(8'h00, rx);
      mst.stop();
      check(rx, {e_ppe, 3'h0, e_bp, e_wel, 1'b0});
      check(status, {e_ppe, 3'h0, e_bp, e_wel, 1'b0});
   endtask
   task automatic wrsr(input logic [7:0] v);
      op1(OP_WREN);
      mst.start();
      mst.xfer(OP_WRSR, rx);
      mst.xfer(v, rx);
      mst.stop();
      if (!(e_ppe && !pins.wp_n)) begin
         e_ppe = v[7];
         e_bp = v[3:2];
      end
      e_wel = 1'b0;
      rdsr();
   endtask
   task automatic burst(input bit wr, input logic [14:0] adr, input int n, input bit hold);
      logic [7:0] d;
      mst.start();
      mst.xfer(wr ? OP_WRITE : OP_READ, rx);
      mst.xfer({1'($urandom), adr[14:8]}, rx);
      mst.xfer(adr[7:0], rx);
      for (int k = 0; k < n; k++) begin
         if (hold && k == 1) begin
            mst.pause();
         end
         d = 8'($urandom);
         mst.xfer(d, rx);
         if (!wr) begin
            check(rx, exp_mem[int'(adr)]);
         end else if (e_wel && !blocked(adr)) begin
            exp_mem[int'(adr)] = d;
         end
         adr++;
      end
      mst.stop();
      if (wr) begin
         e_wel = 1'b0;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #1000000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      n_fail = 0;
      comparisons = 0;
      {e_ppe, e_wel, e_bp} = 4'h0;
      void'($urandom(32'h8A18));
      repeat (8) @(negedge clk);
      rst = 1'b0;
      check(status, SR_RESET);
      check({6'h00, so_oe_n, standby}, 8'h03);
      repeat (3) @(negedge clk);
      for (int m = 0; m < 2; m++) begin
         mst.mode3 = m[0];
         wrsr(8'h00);
         a = (m == 1) ? 15'h7FFD : 15'($urandom);
         op1(OP_WREN);
         burst(1'b1, a, 6, 1'b1);
         rdsr();
         burst(1'b0, a, 6, 1'b1);
         burst(1'b1, a, 2, 1'b0);
         burst(1'b0, a, 2, 1'b0);
         op1(OP_WREN);
         op1(OP_WRDI);
         rdsr();
         burst(1'b1, a, 2, 1'b0);
         burst(1'b0, a, 2, 1'b0);
      end
      for (int b = 0; b < 4; b++) begin
         wrsr({4'h0, 2'(b), 2'h0});
         foreach (a_list[i]) begin
            op1(OP_WREN);
            burst(1'b1, a_list[i], 1, 1'b0);
            burst(1'b0, a_list[i], 1, 1'b0);
         end
      end
      wrsr(8'h80);
      mst.pins.wp_n = 1'b0;
      mst.half();
      wrsr(8'h8C);
      mst.pins.wp_n = 1'b1;
      mst.half();
      wrsr(8'h00);
      mst.start();
      mst.xfer(8'hFF, rx);
      mst.xfer(OP_READ, rx);
      mst.xfer(8'h00, rx);
      // Enough bytes that a wrongly accepted read would reach its data phase
      mst.xfer(8'h00, rx);
      mst.xfer(8'h00, rx);
      check(rx, 8'hFF);
      check({7'h00, so_oe_n}, 8'h01);
      mst.stop();
      tally_and_finish();
   end
endmodule
bind fsp_spi_slave fsp_spi_slave_assertions i_chk (.CLOCK(CLOCK), .RST(RST), .CS_N(CS_N), .SCK(SCK), .SI(SI),
   .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE_N(SO_OE_N), .STANDBY(STANDBY), .STATUS(STATUS));
`default_nettype wire
